// file: rtl/gbc_bus_handler.sv
// Behaviour
// - Interface clear forces local, talker and listener idle
// - Interface clear turns off talk and listen lamps
// - Remote only when addressed to listen with REN
// - Lockout disables all panel inputs including return key
// - Go-to-local leaves remote and cancels lockout only when listening
// - Device clear acts unaddressed, restores defaults
// - Clears keep primary address, errors and remote, restore settings and parser
// - Selective clear restores defaults only when listening
// - Serial poll always returns the status byte
// - Defaults: A0 N0 R3 W0 P0 T0 B0 C1 Z1
// - Defaults: service request off, EOI on, CR LF
// - Commands need listen address, data needs talk address
// - Primary address 0 to 30, factory 22
// - New primary address written to nonvolatile store
// - Unknown command letter raises invalid command error
// - After invalid command discard through next execute
// - Invalid command sets its error status bit
// - Execute without remote raises no-remote error
// - Enabled errors raise a service request
// - In remote only return key and power work
// - Talker idle on untalk, listen address, clear
// - Listener idle on unlisten, talk address, clear
// - Bad option raises option error, discards to execute
module gbc_bus_handler
  import gbc_pkg::*;
#(
  parameter int MSG_CYCLES = `GBC_MSG_MS * (`GBC_CLK_HZ / 1000)
)
(
  input  wire logic                          clk,
  input  wire logic                          srst,
  input  wire logic                          atnN,
  input  wire logic                          ifcN,
  input  wire logic                          renN,
  input  wire logic                          davIn,
  output logic                               davOut,
  output logic                               davOeN,
  input  wire logic                          eoiIn,
  output logic                               eoiOut,
  output logic                               eoiOeN,
  input  wire logic                          nrfdIn,
  output logic                               nrfdOut,
  output logic                               nrfdOeN,
  input  wire logic                          ndacIn,
  output logic                               ndacOut,
  output logic                               ndacOeN,
  output logic                               srqOut,
  output logic                               srqOeN,
  input  wire logic [7:0]                    dioIn,
  output logic      [7:0]                    dioOut,
  output logic      [7:0]                    dioOeN,
  input  wire logic [3:0]                    regAddr,
  input  wire logic [7:0]                    regWrData,
  input  wire logic                          regWr,
  input  wire logic                          regRd,
  output logic      [7:0]                    regRdData,
  input  wire logic [7:0]                    pollStatus,
  input  wire logic [7:0]                    txData,
  input  wire logic                          txLast,
  input  wire logic                          txValid,
  output logic                               txReady,
  input  wire logic                          returnKey,
  input  wire logic [7:0]                    panelKeysIn,
  output logic      [7:0]                    panelKeysOut,
  input  wire logic [4:0]                    nvAddrIn,
  output logic                               nvWr,
  output logic      [4:0]                    nvWrData,
  output logic      [`GBC_SET_N*4-1:0]       settingsOut,
  output logic                               remoteStateLamp,
  output logic                               talkLamp,
  output logic                               listenerActiveLamp,
  output logic                               srqLamp,
  output logic                               msgShow,
  output logic      [`GBC_ERR_W-1:0]         msgCode
);

  localparam logic [`GBC_MSG_CNT_W-1:0] MSG_LOAD = `GBC_MSG_CNT_W'(MSG_CYCLES);

  // Letter to setting slot; bit 4 marks a known letter
  function automatic logic [4:0] letterSlot(input logic [7:0] chr);
    unique case (chr)
      8'h41:   letterSlot = 5'h10;
      8'h4E:   letterSlot = 5'h11;
      8'h52:   letterSlot = 5'h12;
      8'h57:   letterSlot = 5'h13;
      8'h50:   letterSlot = 5'h14;
      8'h54:   letterSlot = 5'h15;
      8'h42:   letterSlot = 5'h16;
      8'h43:   letterSlot = 5'h17;
      8'h5A:   letterSlot = 5'h18;
      8'h4D:   letterSlot = 5'h19;
      8'h4B:   letterSlot = 5'h1A;
      8'h59:   letterSlot = 5'h1B;
      default: letterSlot = 5'h00;
    endcase
  endfunction : letterSlot

  gbc_state_type          st_ff;
  gbc_state_type          nxt_st;
  logic [`GBC_SYNC_W-1:0] pinSync;
  logic                   atn;
  logic                   ifc;
  logic                   ren;
  logic                   dav;
  logic                   nrfd;
  logic                   ndac;
  logic [7:0]             rxByte;
  logic [6:0]             cmd;
  logic                   participate;
  logic                   rxStrobe;
  logic                   txOk;
  logic [7:0]             pollByte;
  logic [`GBC_SET_N-1:0][3:0] setMax;
  logic [`GBC_SET_N-1:0][3:0] setDef;

  assign setMax = `GBC_SET_MAX;
  assign setDef = `GBC_SET_DEFAULT;

  gbc_pin_sync u_pin_sync (
    .clk    (clk),
    .srst   (srst),
    .pinIn  ({atnN, ifcN, renN, davIn, eoiIn, nrfdIn, ndacIn, dioIn}),
    .pinOut (pinSync)
  );

  // Bus lines are low-true
  assign atn    = ~pinSync[`GBC_PIN_ATN];
  assign ifc    = ~pinSync[`GBC_PIN_IFC];
  assign ren    = ~pinSync[`GBC_PIN_REN];
  assign dav    = ~pinSync[`GBC_PIN_DAV];
  assign nrfd   = ~pinSync[`GBC_PIN_NRFD];
  assign ndac   = ~pinSync[`GBC_PIN_NDAC];
  assign rxByte = ~pinSync[`GBC_PIN_DIO_HI:0];
  assign cmd    = rxByte[6:0];

  // Acceptor joins in for every command, and for data only as listener
  assign participate = atn | st_ff.listen;
  assign rxStrobe    = participate & (st_ff.ah == AH_RDY) & dav;

  assign txOk    = st_ff.talk & ~atn & (st_ff.sh == SH_IDLE);
  assign txReady = txOk & ~st_ff.spMode;

  always_comb begin
    pollByte                = pollStatus;
    pollByte[`GBC_POLL_RQS] = st_ff.srqPend;
  end

  always_comb begin
    logic [`GBC_ERR_W-1:0] errEv;
    logic                  clearDev;
    logic                  execNow;
    logic [4:0]            slot;
    logic [3:0]            digit;
    errEv    = '0;
    clearDev = 1'b0;
    execNow  = 1'b0;
    slot     = letterSlot(rxByte);
    digit    = rxByte[3:0];
    nxt_st   = st_ff;
    nxt_st.nvWr     = 1'b0;
    nxt_st.rdData   = 8'h00;
    nxt_st.addrLoad = 1'b0;

    // Stored address comes back from the nonvolatile side after reset
    if (st_ff.addrLoad) begin
      nxt_st.addr = (nvAddrIn > `GBC_ADDR_MAX) ? `GBC_ADDR_FACTORY : nvAddrIn;
    end

    if (st_ff.msgCnt != '0) begin
      nxt_st.msgCnt = st_ff.msgCnt - `GBC_MSG_CNT_W'(1);
    end

    // Acceptor handshake
    unique case (st_ff.ah)
      AH_RDY: begin
        if (rxStrobe) begin
          nxt_st.ah = AH_ACK;
        end
      end
      AH_ACK: begin
        if (!dav) begin
          nxt_st.ah = AH_RDY;
        end
      end
    endcase

    if (rxStrobe && atn) begin
      if (cmd[6:5] == `GBC_GRP_LISTEN) begin
        if (cmd == `GBC_CMD_UNL) begin
          nxt_st.listen = 1'b0;
        end else if (cmd[4:0] == st_ff.addr) begin
          nxt_st.listen = 1'b1;
          nxt_st.talk   = 1'b0;
          if (ren) begin
            nxt_st.remote = 1'b1;
          end
        end
      end else if (cmd[6:5] == `GBC_GRP_TALK) begin
        // Any other talk address also retires this talker
        nxt_st.talk = (cmd[4:0] == st_ff.addr) && (cmd != `GBC_CMD_UNT);
        if (cmd[4:0] == st_ff.addr && cmd != `GBC_CMD_UNT) begin
          nxt_st.listen = 1'b0;
        end
      end else begin
        unique case (cmd)
          `GBC_CMD_GTL: begin
            if (st_ff.listen) begin
              nxt_st.remote  = 1'b0;
              nxt_st.lockout = 1'b0;
            end
          end
          `GBC_CMD_SDC: clearDev = st_ff.listen;
          `GBC_CMD_LLO: nxt_st.lockout = 1'b1;
          `GBC_CMD_DCL: clearDev = 1'b1;
          `GBC_CMD_SPE: nxt_st.spMode = 1'b1;
          `GBC_CMD_SPD: nxt_st.spMode = 1'b0;
          default: ;
        endcase
      end
    end

    // Device-dependent string parser
    if (rxStrobe && !atn) begin
      if (rxByte == `GBC_CHR_EXEC) begin
        if (st_ff.ps == PS_DISCARD) begin
          nxt_st.ps = PS_LETTER;
        end else if (!st_ff.remote) begin
          errEv[`GBC_ERR_NOREM] = 1'b1;
        end else if (st_ff.ps == PS_OPTION) begin
          errEv[`GBC_ERR_OPT] = 1'b1;
        end else begin
          execNow = 1'b1;
        end
        nxt_st.ps    = PS_LETTER;
        nxt_st.pendV = '0;
      end else if (rxByte > `GBC_CHR_SPACE) begin
        unique case (st_ff.ps)
          PS_LETTER: begin
            if (slot[4]) begin
              nxt_st.pIdx = slot[3:0];
              nxt_st.ps   = PS_OPTION;
            end else begin
              errEv[`GBC_ERR_CMD] = 1'b1;
              nxt_st.ps           = PS_DISCARD;
              nxt_st.pendV        = '0;
            end
          end
          PS_OPTION: begin
            if (rxByte >= `GBC_CHR_ZERO && rxByte <= `GBC_CHR_NINE &&
                digit <= setMax[st_ff.pIdx]) begin
              nxt_st.pend[st_ff.pIdx]  = digit;
              nxt_st.pendV[st_ff.pIdx] = 1'b1;
              nxt_st.ps                = PS_LETTER;
            end else begin
              errEv[`GBC_ERR_OPT] = 1'b1;
              nxt_st.ps           = PS_DISCARD;
              nxt_st.pendV        = '0;
            end
          end
          PS_DISCARD: ;
        endcase
      end
    end

    if (execNow) begin
      for (int i = 0; i < `GBC_SET_N; i++) begin
        if (st_ff.pendV[i]) begin
          nxt_st.settings[i] = st_ff.pend[i];
        end
      end
    end

    // Source handshake; serial poll byte goes out in place of user data
    unique case (st_ff.sh)
      SH_IDLE: begin
        if (txOk && st_ff.spMode) begin
          nxt_st.txByte = pollByte;
          nxt_st.txEoi  = 1'b0;
          nxt_st.txPoll = 1'b1;
          nxt_st.sh     = SH_SETTLE;
        end else if (txOk && txValid) begin
          nxt_st.txByte = txData;
          nxt_st.txEoi  = txLast && (st_ff.settings[`GBC_SET_K] == `GBC_EOI_ON);
          nxt_st.txPoll = 1'b0;
          nxt_st.sh     = SH_SETTLE;
        end
      end
      SH_SETTLE: begin
        if (atn || !st_ff.talk) begin
          nxt_st.sh = SH_IDLE;
        end else if (!nrfd) begin
          nxt_st.sh = SH_DAV;
        end
      end
      SH_DAV: begin
        if (atn || !st_ff.talk) begin
          nxt_st.sh = SH_IDLE;
        end else if (!ndac) begin
          nxt_st.sh = SH_IDLE;
          if (st_ff.txPoll) begin
            nxt_st.srqPend = 1'b0;
          end
        end
      end
    endcase

    // Return key works in remote unless locked out; REN loss drops remote
    if (returnKey && !st_ff.lockout) begin
      nxt_st.remote = 1'b0;
    end
    if (!ren) begin
      nxt_st.remote = 1'b0;
    end

    if (clearDev) begin
      nxt_st.settings = setDef;
      nxt_st.pendV    = '0;
      nxt_st.ps       = PS_LETTER;
    end

    if (ifc) begin
      nxt_st.listen = 1'b0;
      nxt_st.talk   = 1'b0;
      nxt_st.remote = 1'b0;
      nxt_st.spMode = 1'b0;
      nxt_st.sh     = SH_IDLE;
    end

    // Register port; error clear loses to a new error in the same cycle
    if (regRd) begin
      unique case (regAddr)
        `GBC_REG_STATUS: nxt_st.rdData = {1'b0, st_ff.msgCnt != '0, st_ff.srqPend,
                                          st_ff.spMode, st_ff.lockout, st_ff.remote,
                                          st_ff.talk, st_ff.listen};
        `GBC_REG_ERROR:  nxt_st.rdData = {5'h0, st_ff.errWord};
        `GBC_REG_ADDR:   nxt_st.rdData = {3'h0, st_ff.addr};
        default:         nxt_st.rdData = 8'h00;
      endcase
    end
    if (regWr && regAddr == `GBC_REG_ERROR) begin
      nxt_st.errWord = st_ff.errWord & ~regWrData[`GBC_ERR_W-1:0];
    end
    if (regWr && regAddr == `GBC_REG_ADDR && regWrData[4:0] <= `GBC_ADDR_MAX &&
        regWrData[7:5] == 3'h0) begin
      nxt_st.addr = regWrData[4:0];
      nxt_st.nvWr = 1'b1;
    end

    if (errEv != '0) begin
      nxt_st.errWord = nxt_st.errWord | errEv;
      nxt_st.msgCode = errEv;
      nxt_st.msgCnt  = MSG_LOAD;
      if ((errEv & st_ff.settings[`GBC_SET_M][`GBC_ERR_W-1:0]) != '0) begin
        nxt_st.srqPend = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_ff          <= '0;
      st_ff.ah       <= AH_RDY;
      st_ff.sh       <= SH_IDLE;
      st_ff.ps       <= PS_LETTER;
      st_ff.settings <= `GBC_SET_DEFAULT;
      st_ff.addr     <= `GBC_ADDR_FACTORY;
      st_ff.addrLoad <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Not-ready while holding a byte; data-not-accepted until it is taken
  assign nrfdOeN = ~(participate & (st_ff.ah == AH_ACK));
  assign ndacOeN = ~(participate & (st_ff.ah == AH_RDY));
  assign davOeN  = ~(st_ff.sh == SH_DAV);
  assign eoiOeN  = ~((st_ff.sh != SH_IDLE) & st_ff.txEoi);
  assign dioOeN  = (st_ff.sh != SH_IDLE) ? ~st_ff.txByte : 8'hFF;
  assign srqOeN  = ~st_ff.srqPend;
  assign davOut  = 1'b0;
  assign eoiOut  = 1'b0;
  assign nrfdOut = 1'b0;
  assign ndacOut = 1'b0;
  assign srqOut  = 1'b0;
  assign dioOut  = 8'h00;

  assign panelKeysOut       = panelKeysIn & {8{~st_ff.remote & ~st_ff.lockout}};
  assign regRdData          = st_ff.rdData;
  assign nvWr               = st_ff.nvWr;
  assign nvWrData           = st_ff.addr;
  assign settingsOut        = st_ff.settings;
  assign remoteStateLamp    = st_ff.remote;
  assign talkLamp           = st_ff.talk;
  assign listenerActiveLamp = st_ff.listen;
  assign srqLamp            = st_ff.srqPend;
  assign msgShow            = st_ff.msgCnt != '0;
  assign msgCode            = st_ff.msgCode;

endmodule : gbc_bus_handler

// file: rtl/gbc_regs.svh
`ifndef GBC_REGS_SVH
`define GBC_REGS_SVH

// Synchronised pin vector: atn, ifc, ren, dav, eoi, nrfd, ndac, dio[7:0]
`define GBC_SYNC_W      15
`define GBC_PIN_IDLE    15'h7FFF
`define GBC_PIN_ATN     14
`define GBC_PIN_IFC     13
`define GBC_PIN_REN     12
`define GBC_PIN_DAV     11
`define GBC_PIN_NRFD    9
`define GBC_PIN_NDAC    8
`define GBC_PIN_DIO_HI  7

// Register port offsets
`define GBC_REG_STATUS  4'h0
`define GBC_REG_ERROR   4'h1
`define GBC_REG_ADDR    4'h2

// Primary address
`define GBC_ADDR_FACTORY 5'h16
`define GBC_ADDR_MAX     5'h1E

// Bus commands sent with ATN, low seven bits
`define GBC_CMD_GTL     7'h01
`define GBC_CMD_SDC     7'h04
`define GBC_CMD_LLO     7'h11
`define GBC_CMD_DCL     7'h14
`define GBC_CMD_SPE     7'h18
`define GBC_CMD_SPD     7'h19
`define GBC_CMD_UNL     7'h3F
`define GBC_CMD_UNT     7'h5F
`define GBC_GRP_LISTEN  2'h1
`define GBC_GRP_TALK    2'h2

// Error status word bits
`define GBC_ERR_W       3
`define GBC_ERR_CMD     0
`define GBC_ERR_OPT     1
`define GBC_ERR_NOREM   2

// Device-dependent command letters and settings
`define GBC_SET_N       12
`define GBC_SET_M       9
`define GBC_SET_K       10
`define GBC_SET_DEFAULT 48'h0001_1000_0300
`define GBC_SET_MAX     48'h3371_1191_1911
`define GBC_CHR_EXEC    8'h58
`define GBC_CHR_SPACE   8'h20
`define GBC_CHR_ZERO    8'h30
`define GBC_CHR_NINE    8'h39
`define GBC_EOI_ON      4'h0
`define GBC_POLL_RQS    6

// Error message display time
`define GBC_CLK_HZ      20000000
`define GBC_MSG_MS      500
`define GBC_MSG_CNT_W   24

`endif

// file: rtl/gbc_pkg.sv
package gbc_pkg;
  `include "gbc_regs.svh"

  typedef enum logic [1:0] {
    AH_RDY = 2'b01,
    AH_ACK = 2'b10
  } gbc_ah_type;

  typedef enum logic [2:0] {
    SH_IDLE   = 3'b001,
    SH_SETTLE = 3'b010,
    SH_DAV    = 3'b100
  } gbc_sh_type;

  typedef enum logic [2:0] {
    PS_LETTER  = 3'b001,
    PS_OPTION  = 3'b010,
    PS_DISCARD = 3'b100
  } gbc_ps_type;

  typedef struct packed {
    logic [`GBC_SYNC_W-1:0] s1;
    logic [`GBC_SYNC_W-1:0] s2;
    logic [`GBC_SYNC_W-1:0] s3;
    logic [`GBC_SYNC_W-1:0] pin;
  } gbc_sync_type;

  typedef struct packed {
    logic                             listen;
    logic                             talk;
    logic                             remote;
    logic                             lockout;
    logic                             spMode;
    logic                             srqPend;
    gbc_ah_type                       ah;
    gbc_sh_type                       sh;
    logic [7:0]                       txByte;
    logic                             txEoi;
    logic                             txPoll;
    gbc_ps_type                       ps;
    logic [3:0]                       pIdx;
    logic [`GBC_SET_N-1:0][3:0]       settings;
    logic [`GBC_SET_N-1:0][3:0]       pend;
    logic [`GBC_SET_N-1:0]            pendV;
    logic [`GBC_ERR_W-1:0]            errWord;
    logic [`GBC_ERR_W-1:0]            msgCode;
    logic [`GBC_MSG_CNT_W-1:0]        msgCnt;
    logic [4:0]                       addr;
    logic                             addrLoad;
    logic                             nvWr;
    logic [7:0]                       rdData;
  } gbc_state_type;
endpackage : gbc_pkg

// file: rtl/gbc_pin_sync.sv
module gbc_pin_sync
  import gbc_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   srst,
  input  wire logic [`GBC_SYNC_W-1:0] pinIn,
  output logic      [`GBC_SYNC_W-1:0] pinOut
);

  gbc_sync_type st_ff;
  gbc_sync_type nxt_st;

  always_comb begin
    nxt_st    = st_ff;
    nxt_st.s1 = pinIn;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
    // A bit moves only when the second and third stages agree
    nxt_st.pin = (st_ff.s2 & st_ff.s3) | (st_ff.pin & (st_ff.s2 ^ st_ff.s3));
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_ff <= '{s1: `GBC_PIN_IDLE, s2: `GBC_PIN_IDLE, s3: `GBC_PIN_IDLE,
                 pin: `GBC_PIN_IDLE};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign pinOut = st_ff.pin;

endmodule : gbc_pin_sync

// file: sim/gbc_bus_checker.sv
`include "gbc_regs.svh"
module gbc_bus_checker (
  input wire logic       clk,
  input wire logic       srst,
  input wire logic       atnN,
  input wire logic       ifcN,
  input wire logic       nrfdOeN,
  input wire logic       ndacOeN,
  input wire logic       srqOeN,
  input wire logic [7:0] dioOeN,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic       regWr,
  input wire logic       nvWr,
  input wire logic [4:0] nvWrData,
  input wire logic [7:0] panelKeysOut,
  input wire logic       remoteStateLamp,
  input wire logic       talkLamp,
  input wire logic       listenerActiveLamp,
  input wire logic       srqLamp,
  input wire logic       msgShow,
  input wire logic [2:0] msgCode
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  // Slack of eight covers the pin synchroniser and the state register
  a_ifc_idle: assert property ((!ifcN)[*8] |-> !talkLamp && !listenerActiveLamp
    && !remoteStateLamp) else $error("clear left a lamp on");
  a_remote_entry: assert property ($rose(remoteStateLamp) |-> listenerActiveLamp)
    else $error("remote without listen");
  a_remote_keys: assert property (remoteStateLamp |-> panelKeysOut == 8'h00)
    else $error("panel keys pass in remote");
  a_talk_listen: assert property (!(talkLamp && listenerActiveLamp))
    else $error("talker and listener together");
  a_dio_talker: assert property (dioOeN != 8'hFF |-> talkLamp)
    else $error("data driven while not talker");
  a_hs_silent: assert property ((atnN && !listenerActiveLamp)[*8] |-> nrfdOeN && ndacOeN)
    else $error("handshake while unaddressed");
  a_addr_store: assert property (regWr && regAddr == `GBC_REG_ADDR && regWrData <= 8'h1E
    |=> nvWr && {3'h0, nvWrData} == $past(regWrData)) else $error("address not stored");
  a_addr_range: assert property (regWr && regAddr == `GBC_REG_ADDR && regWrData > 8'h1E
    |=> !nvWr) else $error("address above range stored");
  a_srq_error: assert property ($rose(srqLamp) |-> msgShow && !srqOeN)
    else $error("service request without an error");
  a_msg_hold: assert property ($rose(msgShow) |-> $onehot(msgCode) ##1 msgShow[*8])
    else $error("error message not shown");
  cover property ($rose(remoteStateLamp));
  cover property ($rose(msgShow));
  cover property (nvWr);
  cover property ($fell(srqLamp));
endmodule : gbc_bus_checker

bind gbc_bus_handler gbc_bus_checker u_gbc_bus_checker (.*);

// file: sim/gbc_ctrl_model.sv
module gbc_ctrl_model (
  input  wire logic       clk,
  input  wire logic       davIn,
  input  wire logic       nrfdIn,
  input  wire logic       ndacIn,
  input  wire logic [7:0] dioIn,
  output logic            atnN,
  output logic            ifcN,
  output logic            renN,
  output logic            cDavN,
  output logic            cNrfdN,
  output logic            cNdacN,
  output logic      [7:0] cDioN
);
  timeunit 1ns;
  timeprecision 1ns;
  wire [2:0] hs = {davIn, ndacIn, nrfdIn};
  initial begin
    {atnN, ifcN, renN, cDavN, cNrfdN, cNdacN} = 6'h3F;
    cDioN = 8'hFF;
  end
  task automatic hold(input int s, input logic v);
    for (int n = 0; n < 400 && hs[s] !== v; n++) @(posedge clk);
  endtask : hold
  task automatic put(input logic atn, input logic [7:0] b);
    @(posedge clk);
    atnN <= !atn;
    // Acceptors need time to see ATN before DAV
    repeat (6) @(posedge clk);
    hold(0, 1'b1);
    cDioN <= ~b;
    repeat (2) @(posedge clk);
    cDavN <= 1'b0;
    @(posedge clk);
    hold(1, 1'b1);
    cDavN <= 1'b1;
    cDioN <= 8'hFF;
  endtask : put
  task automatic get(output logic [7:0] b);
    @(posedge clk);
    atnN <= 1'b1;
    cNdacN <= 1'b0;
    hold(2, 1'b0);
    b = ~dioIn;
    cNrfdN <= 1'b0;
    cNdacN <= 1'b1;
    hold(2, 1'b1);
    cNrfdN <= 1'b1;
  endtask : get
  task automatic ren(input logic v);
    @(posedge clk);
    renN <= !v;
  endtask : ren
  task automatic ifc();
    @(posedge clk);
    ifcN <= 1'b0;
    repeat (2000) @(posedge clk);
    ifcN <= 1'b1;
  endtask : ifc
endmodule : gbc_ctrl_model

// file: sim/tb.sv
`include "gbc_regs.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [7:0] l;
    logic [7:0] d;
    logic [3:0] s;
    logic [3:0] n;
    logic [2:0] e;
  } gbc_row_type;
  localparam gbc_row_type ROWS [6] = '{'{8'h52, 8'h35, 4'h2, 4'h5, 3'h0},
    '{8'h57, 8'h31, 4'h3, 4'h1, 3'h0}, '{8'h57, 8'h32, 4'h3, 4'h1, 3'h2},
    '{8'h46, 8'h31, 4'h2, 4'h5, 3'h1}, '{8'h5A, 8'h30, 4'h8, 4'h0, 3'h0},
    '{8'h52, 8'h39, 4'h2, 4'h9, 3'h0}};
  logic        clk, srst, regWr, regRd, returnKey, txLast, txValid;
  logic [3:0]  regAddr;
  logic [7:0]  regWrData, pollStatus, txData, panelKeysIn, r;
  logic [4:0]  nvAddrIn;
  wire         atnN, ifcN, renN, cDavN, cNrfdN, cNdacN;
  wire  [7:0]  cDioN;
  logic        davOut, davOeN, eoiOut, eoiOeN, nrfdOut, nrfdOeN, ndacOut, ndacOeN;
  logic        srqOut, srqOeN, txReady, nvWr, msgShow, srqLamp;
  logic        remoteStateLamp, talkLamp, listenerActiveLamp;
  logic [7:0]  dioOut, dioOeN, regRdData, panelKeysOut;
  logic [4:0]  nvWrData;
  logic [47:0] settingsOut;
  logic [2:0]  msgCode;
  int          miscompares, cmpCount, cyc;
  // Open-collector lines with pull-ups: any party pulling low wins
  wire         davIn = cDavN & (davOeN | davOut);
  wire         nrfdIn = cNrfdN & (nrfdOeN | nrfdOut);
  wire         ndacIn = cNdacN & (ndacOeN | ndacOut);
  wire         eoiIn = eoiOeN | eoiOut;
  wire  [7:0]  dioIn = cDioN & (dioOeN | dioOut);
  wire  [2:0]  lamps = {remoteStateLamp, talkLamp, listenerActiveLamp};
  gbc_bus_handler #(.MSG_CYCLES(20)) u_gbc_bus_handler (.*);
  gbc_ctrl_model u_ctrl (.*);
  task automatic end_sim();
    if (miscompares == 0 && cmpCount > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_sim
  task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] g);
    cmpCount++;
    if (g !== e) begin
      $display("BAD %s exp %h got %h", nm, e, g);
      miscompares++;
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk);
    regWr <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    #1;
    chk("reg", e, regRdData);
  endtask : rd
  task automatic ec(input logic [2:0] e);
    rd(`GBC_REG_ERROR, {5'h0, e});
    wr(`GBC_REG_ERROR, 8'h07);
  endtask : ec
  task automatic tx(input logic atn, input logic [7:0] b);
    u_ctrl.put(atn, b);
    repeat (4) @(posedge clk);
    #1;
  endtask : tx
  task automatic cmd(input logic [6:0] c);
    tx(1'b1, {1'b0, c});
  endtask : cmd
  task automatic dd(input logic [7:0] l, input logic [7:0] d);
    tx(1'b0, l);
    tx(1'b0, d);
    tx(1'b0, `GBC_CHR_EXEC);
  endtask : dd
  task automatic key();
    @(posedge clk);
    returnKey <= 1'b1;
    repeat (3) @(posedge clk);
    returnKey <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
  endtask : key
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      miscompares++;
      end_sim();
    end
  end
  initial begin
    {srst, regWr, regRd, returnKey, txLast, txValid} = 6'h20;
    {regAddr, regWrData, txData, cyc} = '0;
    panelKeysIn = 8'hA5;
    pollStatus = 8'h21;
    nvAddrIn = 5'h1F;
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    repeat (6) @(posedge clk);
    #1;
    chk("set", `GBC_SET_DEFAULT, settingsOut);
    chk("lamps", 3'h0, lamps);
    chk("txr", 1'b0, txReady);
    rd(`GBC_REG_ADDR, 8'h16);
    rd(4'h7, 8'h00);
    wr(`GBC_REG_ADDR, 8'h1F);
    chk("nvw", 1'b0, nvWr);
    wr(`GBC_REG_ADDR, 8'h1E);
    chk("nvw", 6'h3E, {nvWr, nvWrData});
    rd(`GBC_REG_ADDR, 8'h1E);
    wr(`GBC_REG_ADDR, 8'h16);
    cmd(7'h36);
    tx(1'b0, `GBC_CHR_EXEC);
    ec(3'h4);
    u_ctrl.ren(1'b1);
    repeat (8) @(posedge clk);
    #1;
    chk("lamps", 3'h1, lamps);
    cmd(7'h36);
    chk("lamps", 3'h5, lamps);
    for (int i = 0; i < 6; i++) begin
      dd(ROWS[i].l, ROWS[i].d);
      chk("slot", ROWS[i].n, settingsOut[ROWS[i].s*4 +: 4]);
      ec(ROWS[i].e);
    end
    tx(1'b0, 8'h46);
    tx(1'b0, 8'h31);
    dd(8'h52, 8'h37);
    chk("slot", 4'h9, settingsOut[11:8]);
    chk("code", 3'h1, msgCode);
    ec(3'h1);
    cmd(`GBC_CMD_DCL);
    chk("set", `GBC_SET_DEFAULT, settingsOut);
    rd(`GBC_REG_ADDR, 8'h16);
    dd(8'h52, 8'h35);
    cmd(`GBC_CMD_UNL);
    cmd(`GBC_CMD_SDC);
    chk("slot", 4'h5, settingsOut[11:8]);
    cmd(7'h36);
    cmd(`GBC_CMD_SDC);
    chk("set", `GBC_SET_DEFAULT, settingsOut);
    cmd(`GBC_CMD_LLO);
    key();
    chk("lamps", 3'h5, lamps);
    cmd(`GBC_CMD_GTL);
    chk("lamps", 3'h1, lamps);
    chk("keys", 8'hA5, panelKeysOut);
    cmd(7'h36);
    chk("keys", 8'h00, panelKeysOut);
    key();
    chk("lamps", 3'h1, lamps);
    cmd(7'h36);
    dd(8'h4D, 8'h31);
    dd(8'h46, 8'h31);
    chk("srq", 1'b1, srqLamp);
    ec(3'h1);
    cmd(`GBC_CMD_UNL);
    for (int i = 0; i < 2; i++) begin
      cmd(`GBC_CMD_SPE);
      cmd(7'h56);
      u_ctrl.get(r);
      chk("poll", i ? 8'h21 : 8'h61, r);
      cmd(`GBC_CMD_SPD);
      chk("srq", 1'b0, srqLamp);
    end
    cmd(`GBC_CMD_UNT);
    chk("lamps", 3'h4, lamps);
    cmd(7'h56);
    cmd(7'h36);
    chk("lamps", 3'h5, lamps);
    cmd(7'h56);
    chk("lamps", 3'h6, lamps);
    @(posedge clk);
    {txData, txLast, txValid} <= {8'h3C, 2'b11};
    u_ctrl.get(r);
    chk("tx", 8'h3C, r);
    @(posedge clk);
    txValid <= 1'b0;
    u_ctrl.ifc();
    repeat (4) @(posedge clk);
    #1;
    chk("lamps", 3'h0, lamps);
    end_sim();
  end
endmodule : tb
